/* rtl/svt_pkg.sv */
// Operation
// - Unlocked standard port writes update both copies.
// - Locked standard port writes skip the shadows.
// - Dedicated index writes work regardless of lock.
// - Unlocked only when CRT alone is selected.
// - LCD or TV selection locks shadows automatically.
// - Shadows read only at dedicated indices.
// - Line wraps after horizontal total plus five.
// - Horizontal blank starts at blank-start match.
// - Blank ends at six-bit combined end match.
// - Blank-end bits 6:5 set display-enable skew.
// - Horizontal sync starts at retrace-start match.
// - Horizontal sync ends at five-bit end match.
// - Retrace-end bits 6:5 set sync delay.
// - Vertical total built from shadow and overflow.
// - Vertical blank start built from three sources.
// - Vertical retrace start built from overflow bits.
// - Vertical retrace end uses low four bits.
// - Vertical blank end holds low eight bits.
// - Display end high bits sit in overflow.
// - Panel lock keeps display ends dedicated only.
// - Max-scan bits 7:6 copy sync polarity while unlocked.
// - Enabled centering offset shifts image right.
// - Select bit picks horizontal register set.
package svt_pkg;

  // Number of shadow registers and of those that exist in two sets.
  localparam int SVT_NUM_REGS = 14;
  localparam int SVT_NUM_HSET = 5;

  // Dedicated indices of the shadow registers.
  localparam logic [7:0] SVT_IDX_HTOTAL = 8'h40;
  localparam logic [7:0] SVT_IDX_HBS = 8'h41;
  localparam logic [7:0] SVT_IDX_HBE = 8'h42;
  localparam logic [7:0] SVT_IDX_HRS = 8'h43;
  localparam logic [7:0] SVT_IDX_HRE = 8'h44;
  localparam logic [7:0] SVT_IDX_VTOTAL = 8'h45;
  localparam logic [7:0] SVT_IDX_VBS = 8'h46;
  localparam logic [7:0] SVT_IDX_VBE = 8'h47;
  localparam logic [7:0] SVT_IDX_VRS = 8'h48;
  localparam logic [7:0] SVT_IDX_VRE = 8'h49;
  localparam logic [7:0] SVT_IDX_OVF = 8'h4a;
  localparam logic [7:0] SVT_IDX_MSL = 8'h4b;
  localparam logic [7:0] SVT_IDX_HDE = 8'h4c;
  localparam logic [7:0] SVT_IDX_VDE = 8'h4d;

  // Standard CRTC index mirrored into each shadow, entry 0 is the lowest byte.
  localparam logic [13:0][7:0] SVT_STD_IDX = {8'h12, 8'h01, 8'h09, 8'h07, 8'h11, 8'h10, 8'h16,
                                              8'h15, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h00};
  // Bits that exist in each shadow; the rest read as zero.
  localparam logic [13:0][7:0] SVT_RW_MASK = {8'hff, 8'hff, 8'he0, 8'hef, 8'h0f, 8'hff, 8'hff,
                                              8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff};
  // Bits that a standard port write copies into each shadow.
  localparam logic [13:0][7:0] SVT_MIRROR_MASK = {8'hff, 8'hff, 8'h20, 8'hef, 8'h0f, 8'hff, 8'hff,
                                                  8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff};
  // Bits that the panel lock keeps away from standard port writes.
  localparam logic [13:0][7:0] SVT_PANEL_MASK = {8'hff, 8'hff, 8'h00, 8'h42, 8'h00, 8'h00, 8'h00,
                                                 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Reset value of every shadow register.
  localparam logic [7:0] SVT_SHADOW_RST = 8'h00;

  // Field positions.
  localparam int SVT_SKEW_LSB = 5;
  localparam int SVT_HBE_HI_BIT = 7;
  localparam int SVT_OVF_VT8 = 0;
  localparam int SVT_OVF_VDE8 = 1;
  localparam int SVT_OVF_VRS8 = 2;
  localparam int SVT_OVF_VBS8 = 3;
  localparam int SVT_OVF_VT9 = 5;
  localparam int SVT_OVF_VDE9 = 6;
  localparam int SVT_OVF_VRS9 = 7;
  localparam int SVT_MSL_VBS9 = 5;
  localparam int SVT_POL_LSB = 6;

  // Characters added to the programmed horizontal total, less one for a zero-based count.
  localparam logic [8:0] SVT_HTOTAL_ADD = 9'h005;
  localparam logic [8:0] SVT_HTOTAL_LAST = SVT_HTOTAL_ADD - 9'h001;

  // Host I/O cycle as decoded by the VGA port logic.
  typedef struct packed {
    logic wr;          // Write strobe.
    logic rd;          // Read strobe.
    logic data_port;   // 1 selects the data port, 0 the index port.
    logic misc_wr;     // Write to the miscellaneous output register.
    logic [7:0] wdata; // Write data.
  } svt_host_req_t;

  // Write forwarded to the standard CRT register file.
  typedef struct packed {
    logic wr;
    logic [7:0] index;
    logic [7:0] data;
  } svt_std_wr_t;

  // Shadow timing outputs.
  typedef struct packed {
    logic hblank;
    logic hsync;
    logic vblank;
    logic vsync;
    logic disp_en;
  } svt_timing_t;

endpackage

/* rtl/svt_timing_bank.sv */
`timescale 1ns/100ps
`default_nettype none
module svt_timing_bank
  import svt_pkg::*;
(
  input wire logic clk,                        // Character clock domain clock.
  input wire logic rst_n,                      // Synchronous reset, active low.
  input wire svt_host_req_t host_req,          // Host I/O cycle.
  output svt_std_wr_t std_wr,                  // Write forwarded to standard CRT registers.
  input wire logic [7:0] std_rdata,            // Read data from standard CRT registers.
  output logic [7:0] host_rdata,               // Read data returned to the host.
  output logic host_rvalid,                    // One-cycle pulse with read data.
  input wire logic crt_sel,                    // CRT display selected.
  input wire logic lcd_sel,                    // LCD display selected.
  input wire logic tv_sel,                     // TV display selected.
  input wire logic panel_control_lock_reg,     // Panel lock bit.
  input wire logic horizontal_set_select,      // 1 selects the secondary horizontal set.
  input wire logic [7:0] expansion_centering_control, // Bit 0 enables horizontal centering.
  input wire logic [6:0] hcenter_offset,       // Character units to shift right.
  input wire logic char_tick,                  // One pulse per character time.
  output svt_timing_t timing,                  // Shadow timing signals.
  output logic shadows_locked                  // Shadow lock state.
);

  // Index latched from the index port.
  logic [7:0] index_reg;
  // Shadow storage: entries 0..4 have two sets, the rest have one.
  logic [7:0] hset_reg [2][SVT_NUM_HSET];
  logic [7:0] single_reg [SVT_NUM_REGS];
  // Current view of each shadow as the selected set shows it.
  logic [13:0][7:0] view;

  logic data_wr;
  logic unlocked;
  logic hsel;

  // Lock follows display selection with no software action.
  assign unlocked = crt_sel && !lcd_sel && !tv_sel;
  assign shadows_locked = !unlocked;
  assign data_wr = host_req.wr && host_req.data_port;
  assign hsel = horizontal_set_select;

  // The index port holds the register number for the next data cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      index_reg <= 8'h00;
    end else if (host_req.wr && !host_req.data_port && !host_req.misc_wr) begin
      // A miscellaneous output write shares the strobe but must not move the index.
      index_reg <= host_req.wdata;
    end
  end

  // One generate entry per shadow: dedicated writes always land, mirrored writes only when unlocked.
  for (genvar i = 0; i < SVT_NUM_REGS; i++) begin : g_shadow
    logic ded_hit;
    logic mir_hit;
    logic pol_hit;
    logic [7:0] mir_mask;
    logic [7:0] cur;
    logic [7:0] wr_next;

    assign ded_hit = data_wr && (index_reg == (SVT_IDX_HTOTAL + 8'(i)));
    assign mir_hit = data_wr && unlocked && (index_reg == SVT_STD_IDX[i]);
    // The panel lock strips the display end bits from a mirrored write.
    assign mir_mask = SVT_MIRROR_MASK[i] &
                      ~(panel_control_lock_reg ? SVT_PANEL_MASK[i] : 8'h00);
    // While unlocked, a write to the miscellaneous output register copies its sync polarity bits.
    assign pol_hit = (i == SVT_NUM_REGS - 3) && host_req.wr && host_req.misc_wr && unlocked;
    assign cur = view[i];

    // Merge the write sources; a dedicated write takes the whole register.
    always_comb begin
      wr_next = cur;
      if (ded_hit) begin
        wr_next = host_req.wdata;
      end else if (mir_hit) begin
        wr_next = (cur & ~mir_mask) | (host_req.wdata & mir_mask);
      end else if (pol_hit) begin
        wr_next = {host_req.wdata[7:6], cur[5:0]};
      end
      wr_next = wr_next & SVT_RW_MASK[i];
    end

    if (i < SVT_NUM_HSET) begin : g_dual
      // Only the selected set takes host writes and drives timing.
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          hset_reg[0][i] <= SVT_SHADOW_RST;
          hset_reg[1][i] <= SVT_SHADOW_RST;
        end else if (ded_hit || mir_hit) begin
          hset_reg[hsel][i] <= wr_next;
        end
      end
      assign view[i] = hset_reg[hsel][i];
      assign single_reg[i] = 8'h00;
    end else begin : g_single
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          single_reg[i] <= SVT_SHADOW_RST;
        end else if (ded_hit || mir_hit || pol_hit) begin
          single_reg[i] <= wr_next;
        end
      end
      assign view[i] = single_reg[i];
    end
  end

  // Standard port writes always reach the standard registers, locked or not.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      std_wr <= '0;
    end else begin
      std_wr.wr <= data_wr;
      std_wr.index <= index_reg;
      std_wr.data <= host_req.wdata;
    end
  end

  logic is_shadow_idx;
  assign is_shadow_idx = (index_reg >= SVT_IDX_HTOTAL) && (index_reg <= SVT_IDX_VDE);

  // Reads answer one cycle later; only dedicated indices expose shadow contents.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      host_rdata <= 8'h00;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= host_req.rd;
      if (host_req.rd) begin
        if (!host_req.data_port) begin
          host_rdata <= index_reg;
        end else if (is_shadow_idx) begin
          host_rdata <= view[4'(index_reg - SVT_IDX_HTOTAL)];
        end else begin
          host_rdata <= std_rdata;
        end
      end
    end
  end

  // Decoded compare points.
  logic [8:0] h_last;
  logic [10:0] v_total;
  logic [10:0] v_bstart;
  logic [10:0] v_rstart;
  logic [10:0] v_dend;
  logic [5:0] h_bend;
  logic [1:0] de_skew;
  logic [1:0] hs_delay;
  logic [1:0] sync_pol;
  logic [8:0] h_shift;

  assign h_last = {1'b0, view[0]} + SVT_HTOTAL_LAST;
  assign h_bend = {view[4][SVT_HBE_HI_BIT], view[2][4:0]};
  assign de_skew = view[2][SVT_SKEW_LSB +: 2];
  assign hs_delay = view[4][SVT_SKEW_LSB +: 2];
  assign v_total = {1'b0, view[10][SVT_OVF_VT9], view[10][SVT_OVF_VT8], view[5]};
  assign v_bstart = {1'b0, view[11][SVT_MSL_VBS9], view[10][SVT_OVF_VBS8], view[6]};
  assign v_rstart = {1'b0, view[10][SVT_OVF_VRS9], view[10][SVT_OVF_VRS8], view[8]};
  assign v_dend = {1'b0, view[10][SVT_OVF_VDE9], view[10][SVT_OVF_VDE8], view[13]};
  assign sync_pol = view[11][SVT_POL_LSB +: 2];
  // Centering shifts only the display window; sync timing stays put so the monitor keeps lock.
  assign h_shift = expansion_centering_control[0] ? {2'b00, hcenter_offset} : 9'h000;

  logic [8:0] hcount_reg;
  logic [10:0] vcount_reg;
  logic line_end;
  assign line_end = char_tick && (hcount_reg == h_last);

  // Horizontal character counter.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hcount_reg <= 9'h000;
    end else if (char_tick) begin
      hcount_reg <= line_end ? 9'h000 : hcount_reg + 9'h001;
    end
  end

  // Vertical scan line counter, stepped at each line end.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vcount_reg <= 11'h000;
    end else if (line_end) begin
      vcount_reg <= (vcount_reg == v_total) ? 11'h000 : vcount_reg + 11'h001;
    end
  end

  logic hblank_reg;
  logic hsync_reg;
  logic vblank_reg;
  logic vsync_reg;

  // Horizontal blank: start has priority when both compares hit.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hblank_reg <= 1'b0;
    end else if (char_tick) begin
      if (hcount_reg == {1'b0, view[1]}) begin
        hblank_reg <= 1'b1;
      end else if (hcount_reg[5:0] == h_bend) begin
        hblank_reg <= 1'b0;
      end
    end
  end

  // Horizontal retrace.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hsync_reg <= 1'b0;
    end else if (char_tick) begin
      if (hcount_reg == {1'b0, view[3]}) begin
        hsync_reg <= 1'b1;
      end else if (hcount_reg[4:0] == view[4][4:0]) begin
        hsync_reg <= 1'b0;
      end
    end
  end

  // Vertical blank.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vblank_reg <= 1'b0;
    end else if (line_end) begin
      if (vcount_reg == v_bstart) begin
        vblank_reg <= 1'b1;
      end else if (vcount_reg[7:0] == view[7]) begin
        vblank_reg <= 1'b0;
      end
    end
  end

  // Vertical retrace; reserved upper bits of its end register take no part.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vsync_reg <= 1'b0;
    end else if (line_end) begin
      if (vcount_reg == v_rstart) begin
        vsync_reg <= 1'b1;
      end else if (vcount_reg[3:0] == view[9][3:0]) begin
        vsync_reg <= 1'b0;
      end
    end
  end

  // Raw display enable inside the shifted horizontal window and above the display end line.
  logic de_raw;
  logic [8:0] h_dend_shift;
  assign h_dend_shift = {1'b0, view[12]} + h_shift;
  assign de_raw = (hcount_reg >= h_shift) && (hcount_reg <= h_dend_shift) && (vcount_reg <= v_dend);

  // Delay lines for skew and sync delay, one stage per character time.
  logic [2:0] de_pipe_reg;
  logic [2:0] hs_pipe_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      de_pipe_reg <= 3'h0;
      hs_pipe_reg <= 3'h0;
    end else if (char_tick) begin
      de_pipe_reg <= {de_pipe_reg[1:0], de_raw};
      hs_pipe_reg <= {hs_pipe_reg[1:0], hsync_reg};
    end
  end

  logic de_skewed;
  logic hs_delayed;
  assign de_skewed = (de_skew == 2'd0) ? de_raw : de_pipe_reg[de_skew - 2'd1];
  assign hs_delayed = (hs_delay == 2'd0) ? hsync_reg : hs_pipe_reg[hs_delay - 2'd1];

  // Output flops; a polarity bit of 1 gives an active-low sync.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timing <= '0;
    end else begin
      timing.hblank <= hblank_reg;
      timing.hsync <= hs_delayed ^ sync_pol[0];
      timing.vblank <= vblank_reg;
      timing.vsync <= vsync_reg ^ sync_pol[1];
      timing.disp_en <= de_skewed;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_mirror_write: assert property (data_wr && unlocked && index_reg == 8'h00 |=>
    view[0] == $past(host_req.wdata) || $past(hsel) != hsel)
    else $error("Unlocked standard write missed shadow");
  a_locked_hold: assert property (data_wr && !unlocked && index_reg == 8'h06 |=>
    $stable(view[5]))
    else $error("Locked standard write changed shadow");
  a_dedicated_write: assert property (data_wr && !unlocked && index_reg == SVT_IDX_HTOTAL |=>
    view[0] == $past(host_req.wdata) || $past(hsel) != hsel)
    else $error("Dedicated write lost");
  a_lcd_locks: assert property (lcd_sel || tv_sel |-> shadows_locked)
    else $error("Shadows unlocked while panel selected");
  a_read_path: assert property (host_req.rd && host_req.data_port && index_reg == 8'h00 |=>
    host_rvalid && host_rdata == $past(std_rdata))
    else $error("Standard read returned wrong data");
  a_shadow_read: assert property (host_req.rd && host_req.data_port && index_reg == SVT_IDX_VBE |=>
    host_rdata == $past(view[7]))
    else $error("Shadow read returned wrong data");
  a_htotal_wrap: assert property (char_tick && hcount_reg == {1'b0, view[0]} + 9'h004 |=>
    hcount_reg == 9'h000)
    else $error("Line did not wrap at total plus five");
  a_hblank_start: assert property (char_tick && hcount_reg == {1'b0, view[1]} |=> hblank_reg)
    else $error("Horizontal blank did not start");
  a_hsync_end: assert property (char_tick && hcount_reg != {1'b0, view[3]} &&
    hcount_reg[4:0] == view[4][4:0] |=> !hsync_reg)
    else $error("Horizontal retrace did not end");
  a_panel_guard: assert property (data_wr && panel_control_lock_reg && index_reg == 8'h01 |=>
    $stable(view[12]))
    else $error("Panel lock let display end through");
  a_reserved_zero: assert property (view[9][7:4] == 4'h0 && view[10][4] == 1'b0)
    else $error("Reserved shadow bits not zero");

  c_mirror: cover property (data_wr && unlocked && index_reg == 8'h00);
  c_dedicated_locked: cover property (data_wr && !unlocked && is_shadow_idx);
  c_line_wrap: cover property (line_end);
  c_secondary_write: cover property (data_wr && hsel && index_reg == SVT_IDX_HBS);

endmodule
`default_nettype wire

/* tb/shadow_vga_timing_bank_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module shadow_vga_timing_bank_tb
  import svt_pkg::*;
;
  logic clk; // Character clock, 100 MHz.
  logic rst_n; // Synchronous reset, active low.
  svt_host_req_t host_req; // Host cycle driven by the tasks below.
  svt_std_wr_t std_wr; // Forwarded standard writes.
  logic [7:0] std_rdata; // Standard register read data.
  logic [7:0] host_rdata; // Read data to the host.
  logic host_rvalid; // Read data valid pulse.
  logic crt_sel, lcd_sel, tv_sel; // Display selection.
  logic panel_lock; // Panel lock bit.
  logic hset_sel; // Horizontal set select.
  logic [7:0] center_ctrl; // Centering control, held off.
  logic [6:0] hoff; // Centering offset.
  logic char_tick; // Character tick, held high.
  svt_timing_t timing; // Shadow timing outputs.
  logic shadows_locked; // Lock state.
  int fails; // Mismatch count.
  int comparisons; // Comparison count.

  svt_timing_bank DUT (.clk(clk), .rst_n(rst_n), .host_req(host_req), .std_wr(std_wr), .std_rdata(std_rdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .crt_sel(crt_sel), .lcd_sel(lcd_sel), .tv_sel(tv_sel),
    .panel_control_lock_reg(panel_lock), .horizontal_set_select(hset_sel),
    .expansion_centering_control(center_ctrl), .hcenter_offset(hoff), .char_tick(char_tick),
    .timing(timing), .shadows_locked(shadows_locked));

  svt_std_crt_model MODEL (.clk(clk), .rst_n(rst_n), .host_req(host_req), .std_wr(std_wr),
    .std_rdata(std_rdata));

  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Print the verdict and stop; every path out of the run ends here.
  task automatic end_sim();
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Byte comparison.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Single flag comparison.
  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Pack one host cycle.
  function automatic svt_host_req_t mk(input logic w, input logic r, input logic dp, input logic m,
                                       input logic [7:0] d);
    mk = {w, r, dp, m, d};
  endfunction

  // Drive one request for exactly one edge.
  task automatic put(input svt_host_req_t q);
    @(posedge clk);
    host_req <= q;
  endtask

  // Index write followed by a data write, then idle.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    put(mk(1'b1, 1'b0, 1'b0, 1'b0, idx));
    put(mk(1'b1, 1'b0, 1'b1, 1'b0, d));
    put('0);
  endtask

  // Index write, data read, then a bounded wait for the valid pulse and a comparison.
  task automatic chk_rd(input logic [7:0] idx, input logic [7:0] exp);
    int n;
    put(mk(1'b1, 1'b0, 1'b0, 1'b0, idx));
    put(mk(1'b0, 1'b1, 1'b1, 1'b0, 8'h00));
    put('0);
    n = 0;
    #1;
    while (host_rvalid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 4) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, host_rvalid, 1'b1);
      end_sim();
    end
    chk8(host_rdata, exp);
  endtask

  // Select displays at an edge.
  task automatic sel(input logic [2:0] k);
    @(posedge clk);
    {crt_sel, lcd_sel, tv_sel} <= k;
  endtask

  // All shadows come out of reset cleared.
  task automatic t_reset();
    for (int i = 0; i < 14; i++) begin
      chk_rd(8'h40 + 8'(i), 8'h00);
    end
  endtask

  // Only CRT alone leaves the shadows open; any LCD or TV choice locks them.
  task automatic t_lock_state();
    for (int k = 0; k < 8; k++) begin
      sel(3'(k));
      @(posedge clk);
      #1;
      chk1(shadows_locked, k != 4);
    end
    sel(3'b100);
  endtask

  // Standard writes reach the shadows, masked to their mirrored bits; std reads stay standard.
  task automatic t_mirror();
    logic [7:0] s [0:13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
                             8'h07, 8'h09, 8'h10, 8'h11, 8'h12, 8'h15, 8'h16};
    logic [7:0] d [0:13] = '{8'h40, 8'h4c, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45,
                             8'h4a, 8'h4b, 8'h48, 8'h49, 8'h4d, 8'h46, 8'h47};
    logic [7:0] m [0:13] = '{8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff,
                             8'hef, 8'h20, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff};
    logic [7:0] v;
    for (int i = 0; i < 14; i++) begin
      v = 8'ha5 ^ (8'(i) * 8'h13);
      wr(s[i], v);
      chk_rd(d[i], v & m[i]);
      chk_rd(s[i], v);
    end
  endtask

  // Under LCD and then TV, standard writes stop short of the shadows; dedicated writes still land.
  task automatic t_locked();
    for (int k = 0; k < 2; k++) begin
      sel(k == 0 ? 3'b010 : 3'b001);
      wr(8'h00, 8'h5a + 8'(k));
      chk_rd(8'h40, k == 0 ? 8'ha5 : 8'h3c);
      chk_rd(8'h00, 8'h5a + 8'(k));
      wr(8'h40, 8'h3c + 8'(k));
      chk_rd(8'h40, 8'h3c + 8'(k));
    end
    sel(3'b100);
  endtask

  // Sync polarity copy follows the miscellaneous output only while unlocked.
  task automatic t_misc();
    put(mk(1'b1, 1'b0, 1'b0, 1'b1, 8'h80));
    put('0);
    chk_rd(8'h4b, 8'ha0);
    sel(3'b110);
    put(mk(1'b1, 1'b0, 1'b0, 1'b1, 8'h40));
    put('0);
    chk_rd(8'h4b, 8'ha0);
    sel(3'b100);
  endtask

  // Reserved bits read as zero even after writing ones.
  task automatic t_reserved();
    logic [7:0] a [0:3] = '{8'h42, 8'h49, 8'h4a, 8'h4b};
    logic [7:0] e [0:3] = '{8'h7f, 8'h0f, 8'hef, 8'he0};
    for (int i = 0; i < 4; i++) begin
      wr(a[i], 8'hff);
      chk_rd(a[i], e[i]);
    end
  endtask

  // Panel lock keeps display-end fields away from the standard port.
  task automatic t_panel();
    @(posedge clk);
    panel_lock <= 1'b1;
    wr(8'h4c, 8'h11);
    wr(8'h01, 8'h77);
    chk_rd(8'h4c, 8'h11);
    wr(8'h4a, 8'h00);
    wr(8'h07, 8'hff);
    chk_rd(8'h4a, 8'had);
    @(posedge clk);
    panel_lock <= 1'b0;
    wr(8'h01, 8'h77);
    chk_rd(8'h4c, 8'h77);
  endtask

  // The two horizontal sets hold separate values.
  task automatic t_hset();
    wr(8'h41, 8'h12);
    @(posedge clk);
    hset_sel <= 1'b1;
    wr(8'h41, 8'h34);
    chk_rd(8'h41, 8'h34);
    @(posedge clk);
    hset_sel <= 1'b0;
    chk_rd(8'h41, 8'h12);
  endtask

  // Short line of five characters; count blank and inverted sync over two lines.
  task automatic t_timing();
    int hb;
    int hs;
    wr(8'h40, 8'h00);
    wr(8'h41, 8'h02);
    wr(8'h42, 8'h04);
    wr(8'h43, 8'h01);
    wr(8'h44, 8'h00);
    hb = 0;
    hs = 0;
    // The counter may have to run up to its top before it wraps at the new total.
    repeat (520) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      #1;
      hb += int'(timing.hblank);
      hs += int'(timing.hsync);
    end
    chk8(8'(hb), 8'h04);
    chk8(8'(hs), 8'h02);
  endtask

  // Main sequence.
  initial begin
    fails = 0;
    comparisons = 0;
    rst_n = 1'b0;
    host_req = '0;
    {crt_sel, lcd_sel, tv_sel} = 3'b100;
    panel_lock = 1'b0;
    hset_sel = 1'b0;
    center_ctrl = 8'h00;
    hoff = 7'h00;
    char_tick = 1'b1;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_lock_state();
    t_mirror();
    t_locked();
    t_misc();
    t_reserved();
    t_panel();
    t_hset();
    t_timing();
    end_sim();
  end
endmodule
`default_nettype wire

/* tb/svt_std_crt_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Behavioural stand-in for the standard CRT register file that sits beside the shadow bank.
module svt_std_crt_model
  import svt_pkg::*;
(
  input wire logic clk,                 // Character clock.
  input wire logic rst_n,               // Synchronous reset, active low.
  input wire svt_host_req_t host_req,   // Host cycle, watched to follow the index port.
  input wire svt_std_wr_t std_wr,       // Writes forwarded by the bank.
  output logic [7:0] std_rdata          // Contents at the current index.
);
  logic [7:0] regs_reg [0:255]; // Standard register contents.
  logic [7:0] index_reg;        // Index last written through the index port.

  // Track the index port, since the bank only forwards data writes to us.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      index_reg <= 8'h00;
    end else if (host_req.wr && !host_req.data_port && !host_req.misc_wr) begin
      index_reg <= host_req.wdata;
    end
  end

  // Store every forwarded write; cleared at reset so no read ever shows an unknown.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 256; i++) begin
        regs_reg[i] <= 8'h00;
      end
    end else if (std_wr.wr) begin
      regs_reg[std_wr.index] <= std_wr.data;
    end
  end

  // The bank samples this on a read, so it follows the index without delay.
  assign std_rdata = regs_reg[index_reg];
endmodule
`default_nettype wire
